/* File: verilog/wiper_pkg.sv */
// Constants, field layouts and state codes for the dual wiper control block.
// Assumes a single 200 MHz clock domain; serial pins are synchronised first.
package wiper_pkg;

    // Divider geometry
    localparam int NUM_POTS = 2;
    localparam int NUM_STORED = 4;
    localparam int TAP_BITS = 6;
    localparam int TAPS = 64;

    // Serial slave address: fixed type nibble (arbitrary value) plus strap
    localparam logic [3:0] DEV_TYPE = 4'h5;

    // Instruction byte layout
    localparam int OP_MSB = 7;
    localparam int OP_LSB = 4;
    localparam int IDX_MSB = 3;
    localparam int IDX_LSB = 2;
    localparam int POT_BIT = 0;
    localparam int STEP_UP_BIT = 0;

    // Instruction codes
    localparam logic [3:0] OP_RD_WIPER = 4'h9;
    localparam logic [3:0] OP_WR_WIPER = 4'ha;
    localparam logic [3:0] OP_RD_STORED = 4'hb;
    localparam logic [3:0] OP_WR_STORED = 4'hc;
    localparam logic [3:0] OP_LOAD_WIPER = 4'hd;
    localparam logic [3:0] OP_SAVE_WIPER = 4'he;
    localparam logic [3:0] OP_STEP = 4'h2;

    // Bit counting and tap limits
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [5:0] TAP_MAX = 6'h3f;
    localparam logic [5:0] TAP_MIN = 6'h00;
    localparam logic [5:0] STORED_RESET = 6'h20;

    // APB register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_WIPER = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RESET = 1'b1;
    localparam int WIPER1_LSB = 8;
    localparam int STATUS_WP_BIT = 0;
    localparam int STATUS_BUSY_BIT = 1;
    localparam int STATUS_LOADED_BIT = 2;

    // Synchroniser reset: write protect released, scl and sda idle high
    localparam logic [6:0] SYNC_RESET = 7'h70;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_INSTR = 7'h04,
        ST_DATA = 7'h08,
        ST_ACK = 7'h10,
        ST_SEND = 7'h20,
        ST_GETACK = 7'h40
    } serial_state_t;

endpackage

/* File: verilog/bit_sync.sv */
// Two flip-flop synchroniser for a group of asynchronous levels.
// Assumes each bit is a slow level or a clock far below clk.
`timescale 1ns/10ps
module bit_sync #(
    parameter int WIDTH = 7,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

/* File: verilog/dual_wiper_position_control.sv */
// Dual 64-tap wiper control: two-wire serial slave, wiper and stored
// settings, one-hot tap select, plus a small APB window for software.
// Assumes serial clock, data, strap and write protect pins are asynchronous.
// Overview of operation
// - Two independent dividers, each with 64 taps set by a 6-bit value.
// - Each divider owns a 6-bit wiper position register setting its tap.
// - Each divider has four 6-bit stored-setting registers.
// - After power-up the first stored setting is copied into each wiper.
// - Serial writes reach wiper registers and any stored-setting register.
// - Write protect low refuses stored writes; wiper writes still allowed.
// - Write protect high permits all reads and writes.
// - Only a slave address matching the four strap pins is answered.
// - Serial data is only pulled low, never driven high.
// - All serial transfers are timed by the master's serial clock.
// - Exactly one tap per divider is selected, chosen by its wiper.
// - Instructions copy between a wiper and its own stored settings.
// - A step mode moves the wiper up or down by one.
`timescale 1ns/10ps
module dual_wiper_position_control (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Two-wire serial bus
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Strap and protect pins
    input wire logic dev_addr_bit_0,
    input wire logic dev_addr_bit_1,
    input wire logic dev_addr_bit_2,
    input wire logic dev_addr_bit_3,
    input wire logic write_protect_b,
    // Tap selects
    output logic [63:0] tap_sel_0,
    output logic [63:0] tap_sel_1
);

    logic [6:0] pins_q;
    logic wp_q;
    logic scl_q;
    logic sda_q;
    logic [3:0] strap;
    logic scl_d;
    logic sda_d;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    wiper_pkg::serial_state_t state;
    wiper_pkg::serial_state_t after;
    wiper_pkg::serial_state_t next_after;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [3:0] op;
    logic sel_pot;
    logic [1:0] sel_idx;
    logic byte_end;
    logic ack_ok;
    logic addr_match;
    logic [3:0] op_in;
    logic ins_pot;
    logic [1:0] ins_idx;
    logic [7:0] read_value;
    logic ins_end;
    logic dat_end;
    logic copy_load;
    logic copy_save;
    logic wr_wiper;
    logic wr_stored;
    logic step;
    logic [5:0] stepped;
    logic [1:0][5:0] wiper;
    logic [1:0][3:0][5:0] stored;
    logic load_pending;
    logic [1:0][63:0] tap_q;
    logic bus_en;
    logic [31:0] rdata;
    logic mapped;
    logic apb_access;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    function automatic logic valid_op(input logic [3:0] code);
        valid_op = (code == wiper_pkg::OP_RD_WIPER)
            || (code == wiper_pkg::OP_WR_WIPER)
            || (code == wiper_pkg::OP_RD_STORED)
            || (code == wiper_pkg::OP_WR_STORED)
            || (code == wiper_pkg::OP_LOAD_WIPER)
            || (code == wiper_pkg::OP_SAVE_WIPER)
            || (code == wiper_pkg::OP_STEP);
    endfunction

    function automatic logic refused(input logic [3:0] code, input logic wp);
        refused = ((code == wiper_pkg::OP_SAVE_WIPER)
            || (code == wiper_pkg::OP_WR_STORED)) && !wp;
    endfunction

    // Pin synchronisers
    bit_sync #(
        .WIDTH(7),
        .RESET_VAL(wiper_pkg::SYNC_RESET)
    ) u_pins (
        .clk(clk),
        .rst_b(rst_b),
        .async_in({write_protect_b, scl, sda_in, dev_addr_bit_3,
            dev_addr_bit_2, dev_addr_bit_1, dev_addr_bit_0}),
        .sync_out(pins_q)
    );

    assign wp_q = pins_q[6];
    assign scl_q = pins_q[5];
    assign sda_q = pins_q[4];
    assign strap = pins_q[3:0];

    // Serial clock and data edge detection
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_q;
            sda_d <= sda_q;
        end
    end

    assign scl_rise = scl_q && !scl_d;
    assign scl_fall = !scl_q && scl_d;
    assign start_cond = scl_q && scl_d && sda_d && !sda_q;
    assign stop_cond = scl_q && scl_d && !sda_d && sda_q;
    assign byte_end = scl_fall && (cnt == wiper_pkg::BYTE_BITS);

    // Fields of the byte just received
    assign op_in = shift[wiper_pkg::OP_MSB:wiper_pkg::OP_LSB];
    assign ins_pot = shift[wiper_pkg::POT_BIT];
    assign ins_idx = shift[wiper_pkg::IDX_MSB:wiper_pkg::IDX_LSB];
    assign addr_match = (shift[7:4] == wiper_pkg::DEV_TYPE)
        && (shift[3:0] == strap) && bus_en;
    assign read_value = (op_in == wiper_pkg::OP_RD_WIPER)
        ? {2'b00, wiper[ins_pot]} : {2'b00, stored[ins_pot][ins_idx]};

    // Acknowledge decision and follow-on state
    always_comb begin
        ack_ok = 1'b0;
        next_after = wiper_pkg::ST_IDLE;
        case (state)
            wiper_pkg::ST_ADDR: begin
                ack_ok = addr_match;
                next_after = wiper_pkg::ST_INSTR;
            end
            wiper_pkg::ST_INSTR: begin
                ack_ok = valid_op(op_in) && !refused(op_in, wp_q);
                if ((op_in == wiper_pkg::OP_RD_WIPER)
                    || (op_in == wiper_pkg::OP_RD_STORED)) begin
                    next_after = wiper_pkg::ST_SEND;
                end else if ((op_in == wiper_pkg::OP_WR_WIPER)
                    || (op_in == wiper_pkg::OP_WR_STORED)
                    || (op_in == wiper_pkg::OP_STEP)) begin
                    next_after = wiper_pkg::ST_DATA;
                end
            end
            wiper_pkg::ST_DATA: begin
                ack_ok = !refused(op, wp_q);
                if (op == wiper_pkg::OP_STEP) begin
                    next_after = wiper_pkg::ST_DATA;
                end
            end
            default: begin
                ack_ok = 1'b0;
            end
        endcase
    end

    // Register action strobes
    assign ins_end = (state == wiper_pkg::ST_INSTR) && byte_end && ack_ok;
    assign dat_end = (state == wiper_pkg::ST_DATA) && byte_end && ack_ok;
    assign copy_load = ins_end && (op_in == wiper_pkg::OP_LOAD_WIPER);
    assign copy_save = ins_end && (op_in == wiper_pkg::OP_SAVE_WIPER);
    assign wr_wiper = dat_end && (op == wiper_pkg::OP_WR_WIPER);
    assign wr_stored = dat_end && (op == wiper_pkg::OP_WR_STORED);
    assign step = dat_end && (op == wiper_pkg::OP_STEP);

    // Saturating step of the selected wiper
    always_comb begin
        stepped = wiper[sel_pot];
        if (shift[wiper_pkg::STEP_UP_BIT]) begin
            if (wiper[sel_pot] != wiper_pkg::TAP_MAX) begin
                stepped = wiper[sel_pot] + 6'h01;
            end
        end else if (wiper[sel_pot] != wiper_pkg::TAP_MIN) begin
            stepped = wiper[sel_pot] - 6'h01;
        end
    end

    // Serial slave state machine
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= wiper_pkg::ST_IDLE;
            after <= wiper_pkg::ST_IDLE;
            cnt <= 4'h0;
            shift <= 8'h00;
            tx <= 8'h00;
            op <= 4'h0;
            sel_pot <= 1'b0;
            sel_idx <= 2'h0;
            sda_oe <= 1'b0;
        end else if (start_cond) begin
            state <= wiper_pkg::ST_ADDR;
            cnt <= 4'h0;
            sda_oe <= 1'b0;
        end else if (stop_cond) begin
            state <= wiper_pkg::ST_IDLE;
            sda_oe <= 1'b0;
        end else begin
            case (state)
                wiper_pkg::ST_ADDR, wiper_pkg::ST_INSTR,
                wiper_pkg::ST_DATA: begin
                    if (scl_rise && (cnt != wiper_pkg::BYTE_BITS)) begin
                        shift <= {shift[6:0], sda_q};
                        cnt <= cnt + 4'h1;
                    end else if (byte_end) begin
                        cnt <= 4'h0;
                        if (ack_ok) begin
                            sda_oe <= 1'b1;
                            state <= wiper_pkg::ST_ACK;
                            after <= next_after;
                        end else begin
                            state <= wiper_pkg::ST_IDLE;
                        end
                        if (state == wiper_pkg::ST_INSTR) begin
                            op <= op_in;
                            sel_pot <= ins_pot;
                            sel_idx <= ins_idx;
                            tx <= read_value;
                        end
                    end
                end
                wiper_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        state <= after;
                        if (after == wiper_pkg::ST_SEND) begin
                            sda_oe <= !tx[7];
                            tx <= {tx[6:0], 1'b0};
                            cnt <= 4'h1;
                        end else begin
                            sda_oe <= 1'b0;
                        end
                    end
                end
                wiper_pkg::ST_SEND: begin
                    if (scl_fall) begin
                        if (cnt == wiper_pkg::BYTE_BITS) begin
                            sda_oe <= 1'b0;
                            state <= wiper_pkg::ST_GETACK;
                        end else begin
                            sda_oe <= !tx[7];
                            tx <= {tx[6:0], 1'b0};
                            cnt <= cnt + 4'h1;
                        end
                    end
                end
                wiper_pkg::ST_GETACK: begin
                    if (scl_fall) begin
                        state <= wiper_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= wiper_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Data line is only ever pulled low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // Wiper position registers and power-up recall
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wiper <= '0;
            load_pending <= 1'b1;
        end else if (load_pending) begin
            load_pending <= 1'b0;
            for (int p = 0; p < wiper_pkg::NUM_POTS; p++) begin
                wiper[p] <= stored[p][0];
            end
        end else if (copy_load) begin
            wiper[ins_pot] <= stored[ins_pot][ins_idx];
        end else if (wr_wiper) begin
            wiper[sel_pot] <= shift[5:0];
        end else if (step) begin
            wiper[sel_pot] <= stepped;
        end
    end

    // Stored-setting registers, four per divider
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stored <= {(wiper_pkg::NUM_POTS * wiper_pkg::NUM_STORED)
                {wiper_pkg::STORED_RESET}};
        end else if (copy_save) begin
            stored[ins_pot][ins_idx] <= wiper[ins_pot];
        end else if (wr_stored) begin
            stored[sel_pot][sel_idx] <= shift[5:0];
        end
    end

    // One-hot tap select per divider
    generate
        for (genvar gp = 0; gp < wiper_pkg::NUM_POTS; gp++) begin : g_tap
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    tap_q[gp] <= 64'h0000_0000_0000_0001;
                end else begin
                    tap_q[gp] <= 64'h0000_0000_0000_0001 << wiper[gp];
                end
            end
        end
    endgenerate

    assign tap_sel_0 = tap_q[0];
    assign tap_sel_1 = tap_q[1];

    // APB read decode
    always_comb begin
        rdata = 32'h0000_0000;
        mapped = 1'b1;
        if (paddr == wiper_pkg::ADDR_CTRL) begin
            rdata[wiper_pkg::CTRL_EN_BIT] = bus_en;
        end else if (paddr == wiper_pkg::ADDR_WIPER) begin
            rdata[5:0] = wiper[0];
            rdata[wiper_pkg::WIPER1_LSB +: 6] = wiper[1];
        end else if (paddr == wiper_pkg::ADDR_STATUS) begin
            rdata[wiper_pkg::STATUS_WP_BIT] = wp_q;
            rdata[wiper_pkg::STATUS_BUSY_BIT] = (state != wiper_pkg::ST_IDLE);
            rdata[wiper_pkg::STATUS_LOADED_BIT] = !load_pending;
        end else begin
            mapped = 1'b0;
        end
    end

    assign apb_access = psel && penable && !pready;

    // APB answer: one wait state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apb_access;
            pslverr <= apb_access && !mapped;
            if (apb_access && !pwrite) begin
                prdata <= rdata;
            end
        end
    end

    // Control register: serial bus enable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_en <= wiper_pkg::CTRL_EN_RESET;
        end else if (psel && penable && pready && pwrite
            && (paddr == wiper_pkg::ADDR_CTRL)) begin
            bus_en <= pwdata[wiper_pkg::CTRL_EN_BIT];
        end
    end

    // Checks
    property p_open_drain;
        sda_oe |-> (sda_out == 1'b0) && ((state == wiper_pkg::ST_ACK)
            || (state == wiper_pkg::ST_SEND));
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("data line driven outside ack or send");

    property p_powerup_load;
        $fell(load_pending) |-> (wiper[0] == stored[0][0])
            && (wiper[1] == stored[1][0]);
    endproperty
    a_powerup_load: assert property (p_powerup_load)
        else $error("wiper not loaded from first stored setting");

    property p_tap_follows;
        !load_pending |=> (tap_q[0] == (64'h1 << $past(wiper[0])))
            && (tap_q[1] == (64'h1 << $past(wiper[1])));
    endproperty
    a_tap_follows: assert property (p_tap_follows)
        else $error("tap select does not follow wiper");

    property p_addr_reject;
        (state == wiper_pkg::ST_ADDR) && byte_end && !addr_match
            |=> (state == wiper_pkg::ST_IDLE) && !sda_oe [*2];
    endproperty
    a_addr_reject: assert property (p_addr_reject)
        else $error("unmatched address was answered");

    property p_nv_protect;
        !wp_q |=> stored == $past(stored);
    endproperty
    a_nv_protect: assert property (p_nv_protect)
        else $error("stored setting changed while protected");

    property p_wiper_write;
        wr_wiper |=> wiper[$past(sel_pot)] == $past(shift[5:0]);
    endproperty
    a_wiper_write: assert property (p_wiper_write)
        else $error("wiper write lost");

    property p_nv_write;
        wr_stored |=> stored[$past(sel_pot)][$past(sel_idx)]
            == $past(shift[5:0]);
    endproperty
    a_nv_write: assert property (p_nv_write)
        else $error("stored write lost while unprotected");

    property p_step_top;
        step && shift[wiper_pkg::STEP_UP_BIT]
            && (wiper[sel_pot] == wiper_pkg::TAP_MAX)
            |=> wiper[$past(sel_pot)] == wiper_pkg::TAP_MAX;
    endproperty
    a_step_top: assert property (p_step_top)
        else $error("step up wrapped past top tap");

    property p_shift_on_scl;
        $changed(shift) |-> $past(scl_rise);
    endproperty
    a_shift_on_scl: assert property (p_shift_on_scl)
        else $error("serial bit taken without clock rise");

    property p_copy_load;
        copy_load |=> wiper[$past(ins_pot)] == $past(stored[ins_pot][ins_idx]);
    endproperty
    a_copy_load: assert property (p_copy_load)
        else $error("recall to wiper failed");

    property p_apb_answer;
        apb_access |=> pready ##1 !pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("apb answer not one cycle");

    c_wiper_write: cover property (wr_wiper);
    c_save: cover property (copy_save);
    c_read: cover property ((state == wiper_pkg::ST_SEND)
        ##[1:400] (state == wiper_pkg::ST_GETACK));
    c_refused: cover property ((state == wiper_pkg::ST_INSTR) && byte_end
        && refused(op_in, wp_q));

endmodule

/* File: testbench/serial_master_model.sv */
// Behavioural two-wire bus master; scl runs only within frames, 48 ns.
// Assumes the bench resolves the wired data line with a pull-up.
`timescale 1ns/10ps
module serial_master_model (
    // Resolved data line
    input wire logic sda,
    // Master pins
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // One bit: data set while scl low, sampled late in the high phase
    task automatic clk_bit(input logic b, output logic s);
        #4 sda_low = !b;
        #20 scl = 1'b1;
        #20 s = sda;
        #4 scl = 1'b0;
    endtask
    task automatic start();
        sda_low = 1'b1;
        #24 scl = 1'b0;
    endtask
    task automatic stop();
        #4 sda_low = 1'b1;
        #20 scl = 1'b1;
        #20 sda_low = 1'b0;
        #48;
    endtask
    task automatic byte_out(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], s);
        end
        clk_bit(1'b1, s);
        ack = !s;
    endtask
    task automatic byte_in(output logic [7:0] q);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, q[i]);
        end
        clk_bit(1'b1, s);
    endtask
endmodule

/* File: testbench/dual_wiper_position_control_tb_top.sv */
// Self-checking bench: APB tasks plus serial frames through a master model.
// Assumes the design answers APB with one wait state.
`timescale 1ns/10ps
module dual_wiper_position_control_tb_top;
    logic clk = 1'b0, rst_b = 1'b0, wp_b = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, e, scl, sda_low, sda_out, sda_oe;
    logic [63:0] tap_sel_0, tap_sel_1;
    logic [3:0] strap = 4'h3;
    logic [2:0] a;
    logic [7:0] q8;
    int n_mismatch = 0, cmp_count = 0, cycles = 0;
    wire sda = !(sda_oe | sda_low);
    localparam logic [7:0] ME = {wiper_pkg::DEV_TYPE, 4'h3};
    always #2.5 clk = !clk;
    dual_wiper_position_control dual_wiper_position_control_i (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .dev_addr_bit_0(strap[0]),
        .dev_addr_bit_1(strap[1]), .dev_addr_bit_2(strap[2]),
        .dev_addr_bit_3(strap[3]), .write_protect_b(wp_b),
        .tap_sel_0(tap_sel_0), .tap_sel_1(tap_sel_1));
    serial_master_model serial_master_model_i (
        .sda(sda), .scl(scl), .sda_low(sda_low));
    task automatic print_verdict();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] ad,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [7:0] ins(input logic [3:0] op,
                                       input logic [1:0] idx, input logic p);
        return {op, idx, 1'b0, p};
    endfunction
    // kind 0: no data, 1: one byte written, 2: one byte read
    task automatic frame(input logic [7:0] ad, input logic [7:0] i,
                         input logic [7:0] d, input int kind);
        a = 3'b000;
        serial_master_model_i.start();
        serial_master_model_i.byte_out(ad, a[2]);
        serial_master_model_i.byte_out(i, a[1]);
        if (kind == 1) serial_master_model_i.byte_out(d, a[0]);
        if (kind == 2) serial_master_model_i.byte_in(q8);
        serial_master_model_i.stop();
        repeat (6) @(posedge clk);
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk);
        check(tap_sel_0, 64'h1 << wiper_pkg::STORED_RESET);
        check(tap_sel_1, 64'h1 << wiper_pkg::STORED_RESET);
        apb(1'b0, wiper_pkg::ADDR_WIPER, 32'h0);
        check(q, 32'h2020);
        apb(1'b0, wiper_pkg::ADDR_STATUS, 32'h0);
        check(q[2:0], 3'h5);
        apb(1'b0, 8'h0c, 32'h0);
        check({e, q}, {1'b1, 32'h0});
        frame(ME, ins(wiper_pkg::OP_WR_WIPER, 2'h0, 1'b0), 8'h15, 1);
        check(a, 3'b111);
        check(tap_sel_0, 64'h1 << 8'h15);
        check(tap_sel_1, 64'h1 << 8'h20);
        frame(ME ^ 8'h0f, ins(wiper_pkg::OP_WR_WIPER, 2'h0, 1'b1), 8'h01, 1);
        check(a[2], 1'b0);
        check(tap_sel_1, 64'h1 << 8'h20);
        frame(ME, ins(wiper_pkg::OP_WR_STORED, 2'h2, 1'b1), 8'h2a, 1);
        check(a, 3'b111);
        frame(ME, ins(wiper_pkg::OP_RD_STORED, 2'h2, 1'b1), 8'h00, 2);
        check(q8, 8'h2a);
        frame(ME, ins(wiper_pkg::OP_LOAD_WIPER, 2'h2, 1'b1), 8'h00, 0);
        check(tap_sel_1, 64'h1 << 8'h2a);
        wp_b <= 1'b0;
        frame(ME, ins(wiper_pkg::OP_WR_STORED, 2'h2, 1'b1), 8'h11, 1);
        check(a[1], 1'b0);
        frame(ME, ins(wiper_pkg::OP_SAVE_WIPER, 2'h2, 1'b0), 8'h00, 0);
        check(a[1], 1'b0);
        frame(ME, ins(wiper_pkg::OP_RD_STORED, 2'h2, 1'b1), 8'h00, 2);
        check(q8, 8'h2a);
        frame(ME, ins(wiper_pkg::OP_WR_WIPER, 2'h0, 1'b1), 8'h07, 1);
        check(tap_sel_1, 64'h1 << 8'h07);
        wp_b <= 1'b1;
        frame(ME, ins(wiper_pkg::OP_SAVE_WIPER, 2'h1, 1'b0), 8'h00, 0);
        frame(ME, ins(wiper_pkg::OP_RD_STORED, 2'h1, 1'b0), 8'h00, 2);
        check(q8, 8'h15);
        frame(ME, ins(wiper_pkg::OP_STEP, 2'h0, 1'b0), 8'h01, 1);
        check(tap_sel_0, 64'h1 << 8'h16);
        frame(ME, ins(wiper_pkg::OP_STEP, 2'h0, 1'b0), 8'h00, 1);
        frame(ME, ins(wiper_pkg::OP_STEP, 2'h0, 1'b0), 8'h00, 1);
        apb(1'b0, wiper_pkg::ADDR_WIPER, 32'h0);
        check(q, 32'h0714);
        frame(ME, ins(wiper_pkg::OP_WR_WIPER, 2'h0, 1'b1), 8'h3f, 1);
        frame(ME, ins(wiper_pkg::OP_STEP, 2'h0, 1'b1), 8'h01, 1);
        check(a, 3'b111);
        check(tap_sel_1, 64'h1 << 8'h3f);
        frame(ME, ins(wiper_pkg::OP_RD_WIPER, 2'h0, 1'b1), 8'h00, 2);
        check(q8, 8'h3f);
        frame(ME, ins(4'h0, 2'h0, 1'b0), 8'h00, 0);
        check(a, 3'b100);
        apb(1'b1, wiper_pkg::ADDR_CTRL, 32'h0);
        apb(1'b0, wiper_pkg::ADDR_CTRL, 32'h0);
        check(q, 32'h0);
        frame(ME, ins(wiper_pkg::OP_WR_WIPER, 2'h0, 1'b0), 8'h01, 1);
        check(a, 3'b000);
        check(sda_out, 1'b0);
        print_verdict();
    end
endmodule
